// >>> rss_regs.svh
// Purpose: Offsets, fields, reset values and timing counts for the sequencer
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Hold and dip cycle counts derive from the 10 ns system clock; settle counts oscillator cycles
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

// Register byte offsets
`define RSS_CFG_OFS 8'h00
`define RSS_STATUS_OFS 8'h04
`define RSS_WAKE_EN_OFS 8'h08
`define RSS_WAKE_FLAG_OFS 8'h0C

// Configuration fields
`define RSS_CFG_DIP_EN 0
`define RSS_CFG_POWERUP_HOLD_TIMER_EN 1
`define RSS_CFG_OSC_LO 2
`define RSS_CFG_OSC_HI 3
`define RSS_CFG_WDT_EN 4
`define RSS_CFG_RESET 5'h13

// Status fields
`define RSS_ST_SLEEPING 0
`define RSS_ST_IN_RESET 1
`define RSS_ST_POWERDOWN 3
`define RSS_ST_TIMEOUT 4

// Wake enable fields
`define RSS_WEN_GIE 8
`define RSS_WEN_RESET 9'h000

// Wake source bit positions
`define RSS_SRC_INT_PIN 0
`define RSS_SRC_PORTB 1
`define RSS_SRC_TIMER_ONE 2
`define RSS_SRC_CAPTURE 3
`define RSS_SRC_SPECIAL 4
`define RSS_SRC_SSP_SS 5
`define RSS_SRC_SSP_SLAVE 6
`define RSS_SRC_USART 7
`define RSS_NUM_SRC 8

// Interrupt vector
`define RSS_IRQ_VECTOR 13'h0004

// Timing
`define RSS_CLK_PERIOD_NS 10
`define RSS_POWERUP_HOLD_MS 72
`define RSS_POWERUP_HOLD_CYCLES \
  ((`RSS_POWERUP_HOLD_MS * 1000000) / `RSS_CLK_PERIOD_NS)
`define RSS_DIP_MIN_US 100
`define RSS_DIP_MIN_CYCLES \
  ((`RSS_DIP_MIN_US * 1000 + `RSS_CLK_PERIOD_NS - 1) / `RSS_CLK_PERIOD_NS)
`define RSS_OSC_SETTLE_CYCLES 1024

`endif

// >>> rss_pkg.sv
// Purpose: Types shared by the sequencer
// Assumes: Nothing
// Notes: State codes written out in binary
package rss_pkg;

  typedef enum logic [2:0] {
    RSS_POWERUP = 3'b000,
    RSS_DIP_HOLD = 3'b001,
    RSS_OSC = 3'b010,
    RSS_RUN = 3'b011,
    RSS_SLEEP = 3'b100,
    RSS_PIN_HOLD = 3'b101
  } rss_state_t;

  typedef enum logic [1:0] {
    RSS_MODE_LP = 2'b00,
    RSS_MODE_XT = 2'b01,
    RSS_MODE_HS = 2'b10,
    RSS_MODE_RC = 2'b11
  } rss_osc_mode_t;

endpackage

// >>> rss_sync.sv
// Purpose: Two-flop synchroniser, one per bit
// Assumes: Inputs asynchronous to clk
// Notes: First stage feeds only the second
module rss_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic stage1;
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          stage1 <= INIT[i];
          dout[i] <= INIT[i];
        end
        else
        begin
          stage1 <= din[i];
          dout[i] <= stage1;
        end
      end
    end
  endgenerate

endmodule // rss_sync

// >>> rss_sequencer.sv
// Purpose: Start-up, supply-dip reset, sleep entry and wake-up sequencing
// Assumes: rstn is the power-on reset; core instruction strobes on clk
// Notes: Registers on APB; pins pass the two-flop synchroniser
//
// Contract
// - Hold reset 1024 oscillator cycles after powerup
// - Settle only in crystal modes, POR/wake
// - Config bit enables supply dip reset
// - Dip longer than minimum causes reset
// - Hold until supply recovers, then powerup hold
// - Dip during powerup hold restarts sequence
// - Dip reset enable forces powerup timer
// - Sleep clears watchdog and powerdown flag, sets timeout flag, stops oscillator
// - Pins keep their state during sleep
// - Wake on pin reset, watchdog, interrupt
// - Pin reset fully resets; others resume
// - Flags tell powerup, sleep and watchdog wake
// - Only listed peripheral interrupts can wake
// - Sleep prefetches next program address
// - Wake needs source enable, ignores global
// - Global enable set vectors to 0004h
// - Pending interrupt turns sleep into no-op
// - Late interrupt: full sleep, then wake
// - Powerup timer holds reset, config enabled
// - Watchdog clear sets both flags
`include "rss_regs.svh"

module rss_sequencer
  import rss_pkg::*;
#(
  parameter int POWERUP_CYCLES = `RSS_POWERUP_HOLD_CYCLES,
  parameter int DIP_MIN_CYCLES = `RSS_DIP_MIN_CYCLES,
  parameter int OSC_CYCLES = `RSS_OSC_SETTLE_CYCLES,
  parameter int PC_W = 13
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_reset_pin_n,
  input wire logic supply_low,
  input wire logic osc_in,
  input wire logic [`RSS_NUM_SRC-1:0] wake_flag,
  input wire logic watchdog_timeout,
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic [PC_W-1:0] pc,
  output logic device_reset,
  output logic osc_driver_en,
  output logic io_hold,
  output logic watchdog_clear,
  output logic prefetch_req,
  output logic [PC_W-1:0] prefetch_addr,
  output logic resume,
  output logic vector_req,
  output logic [PC_W-1:0] vector_addr,
  output logic powerdown_flag,
  output logic timeout_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int SYNC_W = `RSS_NUM_SRC + 3;
  localparam logic [SYNC_W-1:0] SYNC_INIT = {1'b1, {(SYNC_W - 1){1'b0}}};

  logic [SYNC_W-1:0] sync_out;
  logic pin_n, low, osc_s;
  logic [`RSS_NUM_SRC-1:0] flag_s;

  rss_sync #(
    .WIDTH(SYNC_W),
    .INIT(SYNC_INIT)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({external_reset_pin_n, supply_low, osc_in, wake_flag}),
    .dout(sync_out)
  );

  assign pin_n = sync_out[SYNC_W-1];
  assign low = sync_out[SYNC_W-2];
  assign osc_s = sync_out[SYNC_W-3];
  assign flag_s = sync_out[`RSS_NUM_SRC-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Registers and APB
  logic [4:0] cfg;
  logic [8:0] wake_en;
  rss_state_t state;
  logic dip_en, powerup_hold_timer_active, crystal, wdt_en, global_irq_enable;
  logic wr, setup, mapped;
  logic [31:0] next_rdata;

  assign dip_en = cfg[`RSS_CFG_DIP_EN];
  assign powerup_hold_timer_active = cfg[`RSS_CFG_POWERUP_HOLD_TIMER_EN] | dip_en;
  assign crystal = rss_osc_mode_t'(cfg[`RSS_CFG_OSC_HI:`RSS_CFG_OSC_LO])
    != RSS_MODE_RC;
  assign wdt_en = cfg[`RSS_CFG_WDT_EN];
  assign global_irq_enable = wake_en[`RSS_WEN_GIE];

  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & pready;
  assign pready = 1'b1;
  assign mapped = (paddr == `RSS_CFG_OFS) || (paddr == `RSS_STATUS_OFS)
    || (paddr == `RSS_WAKE_EN_OFS) || (paddr == `RSS_WAKE_FLAG_OFS);
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cfg <= `RSS_CFG_RESET;
    else if (wr && paddr == `RSS_CFG_OFS)
      cfg <= pwdata[4:0];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wake_en <= `RSS_WEN_RESET;
    else if (wr && paddr == `RSS_WAKE_EN_OFS)
      wake_en <= pwdata[8:0];
  end

  always_comb
  begin
    next_rdata = 32'h00000000;
    case (paddr)
      `RSS_CFG_OFS: next_rdata[4:0] = cfg;
      `RSS_STATUS_OFS:
      begin
        next_rdata[`RSS_ST_SLEEPING] = (state == RSS_SLEEP);
        next_rdata[`RSS_ST_IN_RESET] = device_reset;
        next_rdata[`RSS_ST_POWERDOWN] = powerdown_flag;
        next_rdata[`RSS_ST_TIMEOUT] = timeout_flag;
      end
      `RSS_WAKE_EN_OFS: next_rdata[8:0] = wake_en;
      `RSS_WAKE_FLAG_OFS: next_rdata[`RSS_NUM_SRC-1:0] = flag_s;
      default: next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      prdata <= 32'h00000000;
    else if (setup)
      prdata <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timers
  logic [22:0] powerup_hold_timer_cnt;
  logic [13:0] dip_cnt;
  logic [10:0] osc_cnt;
  logic osc_prev, osc_rise, powerup_hold_timer_done, dip_trip, osc_done;
  logic wake_pend, from_sleep;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      osc_prev <= 1'b0;
    else
      osc_prev <= osc_s;
  end

  assign osc_rise = osc_s & ~osc_prev;

  // Supply dip must last the minimum time
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      dip_cnt <= 14'h0000;
    else if (!low || !dip_en)
      dip_cnt <= 14'h0000;
    else if (!dip_trip)
      dip_cnt <= dip_cnt + 14'h0001;
  end

  assign dip_trip = dip_en && (dip_cnt >= 14'(DIP_MIN_CYCLES));

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      powerup_hold_timer_cnt <= 23'h000000;
    else if (state != RSS_POWERUP)
      powerup_hold_timer_cnt <= 23'h000000;
    else if (!powerup_hold_timer_done)
      powerup_hold_timer_cnt <= powerup_hold_timer_cnt + 23'h000001;
  end

  assign powerup_hold_timer_done = !powerup_hold_timer_active || (powerup_hold_timer_cnt >= 23'(POWERUP_CYCLES));

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      osc_cnt <= 11'h000;
    else if (state != RSS_OSC)
      osc_cnt <= 11'h000;
    else if (osc_rise && !osc_done)
      osc_cnt <= osc_cnt + 11'h001;
  end

  assign osc_done = osc_cnt >= 11'(OSC_CYCLES);

  assign wake_pend = |(flag_s & wake_en[`RSS_NUM_SRC-1:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= RSS_POWERUP;
      from_sleep <= 1'b0;
    end
    else if (!pin_n)
    begin
      if (state != RSS_PIN_HOLD)
        from_sleep <= (state == RSS_SLEEP);
      state <= RSS_PIN_HOLD;
    end
    else if (dip_trip || (dip_en && low && state == RSS_POWERUP))
    begin
      from_sleep <= 1'b0;
      state <= RSS_DIP_HOLD;
    end
    else
    begin
      case (state)
        RSS_DIP_HOLD:
        begin
          if (!low)
            state <= RSS_POWERUP;
        end
        RSS_POWERUP:
        begin
          if (powerup_hold_timer_done)
            state <= crystal ? RSS_OSC : RSS_RUN;
        end
        RSS_OSC:
        begin
          if (osc_done)
            state <= RSS_RUN;
        end
        RSS_RUN:
        begin
          if (sleep_instr && !wake_pend)
            state <= RSS_SLEEP;
        end
        RSS_SLEEP:
        begin
          if (wake_pend || (wdt_en && watchdog_timeout))
          begin
            from_sleep <= 1'b1;
            state <= crystal ? RSS_OSC : RSS_RUN;
          end
        end
        RSS_PIN_HOLD:
        begin
          from_sleep <= 1'b0;
          state <= (crystal && from_sleep) ? RSS_OSC : RSS_RUN;
        end
        default: state <= RSS_POWERUP;
      endcase
    end
  end

  // Reset held during start-up steps and pin-reset settling, not during interrupt or watchdog wake settling
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      device_reset <= 1'b1;
    else
      device_reset <= (state == RSS_POWERUP) || (state == RSS_DIP_HOLD)
        || (state == RSS_PIN_HOLD)
        || (state == RSS_OSC && !from_sleep);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_driver_en <= 1'b1;
      io_hold <= 1'b0;
    end
    else
    begin
      osc_driver_en <= (state != RSS_SLEEP);
      io_hold <= (state == RSS_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags and strobes
  logic sleep_go, wake_go, wdt_wake;

  assign sleep_go = (state == RSS_RUN) && pin_n && !dip_trip
    && sleep_instr && !wake_pend;
  assign wdt_wake = (state == RSS_SLEEP) && wdt_en && watchdog_timeout;
  assign wake_go = (state == RSS_SLEEP) && pin_n && !dip_trip
    && (wake_pend || wdt_wake);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      powerdown_flag <= 1'b1;
      timeout_flag <= 1'b1;
    end
    else if (sleep_go)
    begin
      powerdown_flag <= 1'b0;
      timeout_flag <= 1'b1;
    end
    else if (watchdog_clear_instr && state == RSS_RUN)
    begin
      powerdown_flag <= 1'b1;
      timeout_flag <= 1'b1;
    end
    else if (wake_go && wdt_wake && !wake_pend)
      timeout_flag <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      watchdog_clear <= 1'b0;
      prefetch_req <= 1'b0;
      prefetch_addr <= '0;
    end
    else
    begin
      watchdog_clear <= sleep_go
        || (watchdog_clear_instr && state == RSS_RUN);
      prefetch_req <= sleep_instr && state == RSS_RUN;
      if (sleep_instr && state == RSS_RUN)
        prefetch_addr <= pc + PC_W'(1);
    end
  end

  // Wake resumes without reset; global enable adds the vector
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      resume <= 1'b0;
      vector_req <= 1'b0;
      vector_addr <= '0;
    end
    else
    begin
      resume <= wake_go;
      vector_req <= wake_go && wake_pend && global_irq_enable;
      vector_addr <= PC_W'(`RSS_IRQ_VECTOR);
    end
  end

endmodule // rss_sequencer

// >>> rss_seq_properties.sv
// Purpose: Port-level checks on the sequencer
// Assumes: Sees only the sequencer ports
// Notes: Bound at the foot of the file
module rss_seq_properties #(
  parameter int PC_W = 13
) (
  input logic clk,
  input logic rstn,
  input logic psel,
  input logic penable,
  input logic [7:0] paddr,
  input logic pready,
  input logic pslverr,
  input logic sleep_instr,
  input logic watchdog_clear_instr,
  input logic [PC_W-1:0] pc,
  input logic device_reset,
  input logic osc_driver_en,
  input logic io_hold,
  input logic watchdog_clear,
  input logic prefetch_req,
  input logic [PC_W-1:0] prefetch_addr,
  input logic resume,
  input logic vector_req,
  input logic [PC_W-1:0] vector_addr,
  input logic powerdown_flag,
  input logic timeout_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  property p_pf;
    sleep_instr && !device_reset && !io_hold && osc_driver_en
      |=> prefetch_req && prefetch_addr == $past(pc) + 1'b1;
  endproperty
  a_pf: assert property (p_pf) else $error("no prefetch");
  property p_full;
    prefetch_req && watchdog_clear |-> !powerdown_flag && timeout_flag;
  endproperty
  a_full: assert property (p_full) else $error("sleep flags");
  property p_noop;
    prefetch_req && !watchdog_clear |-> powerdown_flag ==
      $past(powerdown_flag) && timeout_flag == $past(timeout_flag)
      ##1 !io_hold ##1 !io_hold;
  endproperty
  a_noop: assert property (p_noop) else $error("noop sleep");
  property p_wdc;
    watchdog_clear_instr && !sleep_instr && !device_reset && !io_hold
      |=> watchdog_clear && powerdown_flag && timeout_flag;
  endproperty
  a_wdc: assert property (p_wdc) else $error("clear flags");
  property p_hold;
    $rose(io_hold) |-> !osc_driver_en && !device_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("sleep hold");
  property p_res;
    resume |-> !device_reset ##1 !resume;
  endproperty
  a_res: assert property (p_res) else $error("resume");
  property p_vreq;
    vector_req |-> resume;
  endproperty
  a_vreq: assert property (p_vreq) else $error("vector req");
  property p_vec;
    !device_reset |-> vector_addr == 13'h0004;
  endproperty
  a_vec: assert property (p_vec) else $error("vector addr");
  property p_err;
    psel && penable && paddr > 8'h0C |-> pslverr && pready;
  endproperty
  a_err: assert property (p_err) else $error("unmapped");
endmodule // rss_seq_properties
////////////////////////////////////////////////////////////////////////////
bind rss_sequencer rss_seq_properties #(.PC_W(PC_W))
  rss_seq_properties_inst (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .sleep_instr(sleep_instr), .watchdog_clear_instr(watchdog_clear_instr),
  .pc(pc), .device_reset(device_reset), .osc_driver_en(osc_driver_en),
  .io_hold(io_hold), .watchdog_clear(watchdog_clear),
  .prefetch_req(prefetch_req), .prefetch_addr(prefetch_addr),
  .resume(resume), .vector_req(vector_req), .vector_addr(vector_addr),
  .powerdown_flag(powerdown_flag), .timeout_flag(timeout_flag));

// >>> rss_far_side.sv
// Purpose: Reset pin, supply monitor and crystal
// Assumes: Commands from the bench
// Notes: Crystal stands low when not driven
module rss_far_side (
  input logic osc_driver_en,
  input logic osc_stop,
  input logic pin_low,
  input logic dip,
  output logic osc_in,
  output logic external_reset_pin_n,
  output logic supply_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial osc_in = 1'b0;
  always #13 osc_in = osc_driver_en && !osc_stop && !osc_in;
  assign supply_low = dip;
  assign external_reset_pin_n = !pin_low;
endmodule // rss_far_side

// >>> tb.sv
// Purpose: Self-checking bench for the sequencer
// Assumes: Shortened counts 50, 8, 16
// Notes: APB tasks, strobes at the rising edge
`include "rss_regs.svh"
`define CHK(nm, ex, sn) begin total_checks++; if ((sn) !== (ex)) begin \
  failures++; $display("[ERR] %s exp %0h got %0h", nm, ex, sn); end end
`define WAIT(c) begin n = 0; do begin @(posedge clk); #1; n++; end \
  while (!(c) && n < 3000); `CHK("wait", 1'b1, (c)) end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic si = 0, wci = 0, wt = 0, osc_stop = 0, pin_low = 0, dip = 0;
  logic [7:0] paddr = 8'h00, wake_flag = 8'h00;
  logic [31:0] pwdata = 32'h0, q, prdata;
  logic [12:0] pc = 13'h0000, pf_a, v_a;
  logic pready, pslverr, pin_n, sup, osc, dr, oe, ioh, wdc, pf, res, vr;
  logic pdf, tof;
  int failures = 0, total_checks = 0, n, i;
  always #5 clk = ~clk;
  always @(posedge clk) pc <= pc + 13'h1;
  rss_sequencer #(.POWERUP_CYCLES(50), .DIP_MIN_CYCLES(8),
    .OSC_CYCLES(16)) rss_sequencer_inst (.clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_reset_pin_n(pin_n), .supply_low(sup), .osc_in(osc),
    .wake_flag(wake_flag), .watchdog_timeout(wt), .sleep_instr(si),
    .watchdog_clear_instr(wci), .pc(pc), .device_reset(dr),
    .osc_driver_en(oe), .io_hold(ioh), .watchdog_clear(wdc),
    .prefetch_req(pf), .prefetch_addr(pf_a), .resume(res),
    .vector_req(vr), .vector_addr(v_a), .powerdown_flag(pdf),
    .timeout_flag(tof));
  rss_far_side rss_far_side_inst (.osc_driver_en(oe), .osc_stop(osc_stop),
    .pin_low(pin_low), .dip(dip), .osc_in(osc),
    .external_reset_pin_n(pin_n), .supply_low(sup));
  ////////////////////////////////////////////////////////////////////////////
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata; e = pslverr; psel <= 0; penable <= 0;
  endtask
  task slp;
    @(posedge clk);
    wci <= 1;
    @(posedge clk);
    wci <= 0; si <= 1;
    @(posedge clk);
    si <= 0;
  endtask
  task results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    failures++;
    results;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    `WAIT(!dr) `CHK("boot", 1'b1, n > 89)
    apb(0, `RSS_CFG_OFS, 0); `CHK("cfg", 32'h13, q)
    apb(1, `RSS_STATUS_OFS, 0);
    apb(0, `RSS_STATUS_OFS, 0); `CHK("status", 32'h18, q)
    apb(0, 8'h10, 0); `CHK("unmapped", 1'b1, e)
    apb(1, `RSS_CFG_OFS, 32'h1D); osc_stop <= 1; dip <= 1;
    repeat (20) @(posedge clk); dip <= 0;
    repeat (20) @(posedge clk); dip <= 1;
    repeat (3) @(posedge clk); dip <= 0;
    `WAIT(!dr) `CHK("dip", 1'b1, n >= 50 && n < 70)
    apb(1, `RSS_CFG_OFS, 32'h1C); dip <= 1;
    repeat (20) @(posedge clk); dip <= 0; osc_stop <= 0;
    #1 `CHK("dip_off", 1'b0, dr)
    for (i = 0; i < 8; i++)
    begin
      apb(1, `RSS_WAKE_EN_OFS, (32'h1 << i) | ((i % 2) << 8));
      slp; `WAIT(ioh) `CHK("osc_off", 1'b0, oe)
      @(posedge clk) wake_flag[(i + 1) % 8] <= 1'b1;
      repeat (10) @(posedge clk); #1 `CHK("asleep", 1'b1, ioh)
      @(posedge clk) wake_flag[i] <= 1'b1;
      `WAIT(res) `CHK("vector", 1'((i % 2)), vr)
      `CHK("no_reset", 1'b0, dr)
      @(posedge clk) wake_flag <= 8'h00;
      repeat (4) @(posedge clk);
    end
    apb(1, `RSS_WAKE_EN_OFS, 32'h1); wake_flag <= 8'h01;
    repeat (4) @(posedge clk);
    slp; repeat (4) @(posedge clk); #1 `CHK("noop", 1'b0, ioh)
    `CHK("noop_pd", 1'b1, pdf)
    @(posedge clk) wake_flag <= 8'h00;
    repeat (4) @(posedge clk);
    slp; `WAIT(ioh)
    @(posedge clk) wt <= 1;
    @(posedge clk) wt <= 0;
    #1 `CHK("wdt_res", 1'b1, res)
    `CHK("wdt_wake", 1'b0, tof)
    slp; `WAIT(ioh)
    @(posedge clk) pin_low <= 1;
    `WAIT(dr) `CHK("pin_rst", 1'b1, dr)
    @(posedge clk) pin_low <= 0;
    `WAIT(!dr) `CHK("pin_rel", 1'b1, n < 20)
    apb(1, `RSS_CFG_OFS, 32'h04); slp; `WAIT(ioh)
    @(posedge clk) wt <= 1;
    @(posedge clk) wt <= 0;
    apb(0, `RSS_STATUS_OFS, 0); `CHK("st_sleep", 32'h11, q)
    @(posedge clk) wake_flag <= 8'h01;
    `WAIT(res) `CHK("wake_rst", 1'b0, dr)
    repeat (20) @(posedge clk); #1 `CHK("settle_rst", 1'b0, dr)
    @(posedge clk) wake_flag <= 8'h00;
    repeat (60) @(posedge clk);
    slp; `WAIT(ioh)
    @(posedge clk) pin_low <= 1;
    `WAIT(dr)
    @(posedge clk) pin_low <= 0;
    `WAIT(!dr) `CHK("pin_settle", 1'b1, n > 30 && n < 80)
    results;
  end
endmodule // tb
